// ==== verilog/mpc_params.svh ====
// Purpose: Register indexes, reset values and bus codes of the motor port pin control
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef MPC_PARAMS_SVH
`define MPC_PARAMS_SVH

`define MPC_IDX_U_DATA 4'h0
`define MPC_IDX_U_IN 4'h1
`define MPC_IDX_U_DIR 4'h2
`define MPC_IDX_U_SLEW 4'h3
`define MPC_IDX_U_PE 4'h4
`define MPC_IDX_U_POL 4'h5
`define MPC_IDX_V_DATA 4'h6
`define MPC_IDX_V_IN 4'h7
`define MPC_IDX_V_DIR 4'h8
`define MPC_IDX_V_SLEW 4'h9
`define MPC_IDX_V_PE 4'hA
`define MPC_IDX_V_POL 4'hB
`define MPC_IDX_LAST 4'hB

`define MPC_RST_DATA 8'h00
`define MPC_RST_DIR 8'h00
`define MPC_RST_SLEW 8'h00
`define MPC_RST_PE 8'h00
`define MPC_RST_POL 8'h00
`define MPC_RST_IBUF 16'hFFFF

`define MPC_HRESP_OKAY 1'b0
`define MPC_RD_WAIT_CYCLES 1

`endif

// ==== verilog/mpc_pkg.sv ====
// Purpose: Types of the motor port pin control
// Assumes: Used together with mpc_params.svh
// Notes: Bus phase codes are Gray along idle, write, read
package mpc_pkg;
  typedef enum logic [1:0] {
    MPC_PH_IDLE = 2'b00,
    MPC_PH_WR = 2'b01,
    MPC_PH_RD = 2'b11
  } mpc_phase_t;
endpackage : mpc_pkg

// ==== verilog/mpc_port_ctrl.sv ====
// Purpose: Pin control of two 8-bit motor ports shared by stall detectors, motor PWM and GPIO
// Assumes: AHB-Lite slave, single word transfers, peripherals on hclk
// Notes: Reads take one wait state, writes none
`include "mpc_params.svh"

module mpc_port_ctrl
  import mpc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Peripherals, one group of four pins each, group 0 is port U low
  input wire logic [3:0] stall_en,
  input wire logic [15:0] stall_out,
  input wire logic [3:0] pwm_en,
  input wire logic [15:0] pwm_out,
  // Pins, bits 7..0 port U, bits 15..8 port V
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  output logic [15:0] pin_pull_up,
  output logic [15:0] pin_pull_down,
  output logic [15:0] pin_slew,
  output logic [15:0] pin_ibuf_en
);

  mpc_phase_t phase_reg, phase_next;
  logic [3:0] idx_reg, idx_next;
  logic hreadyout_reg, hreadyout_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic hresp_reg;
  logic [7:0] port_u_pin_data_reg, port_u_direction_reg, port_u_slew_control_reg;
  logic [7:0] port_u_pull_enable_reg, port_u_pull_polarity_reg;
  logic [7:0] port_v_pin_data_reg, port_v_direction_reg, port_v_slew_control_reg;
  logic [7:0] port_v_pull_enable_reg, port_v_pull_polarity_reg;
  logic [15:0] pin_sync1_reg, pin_sync2_reg;
  logic [15:0] pin_out_reg, pin_oe_reg, pin_pull_up_reg, pin_pull_down_reg;
  logic [15:0] pin_slew_reg, pin_ibuf_en_reg;

  wire take;
  wire wr_en;
  wire rd_fill;
  wire [15:0] wr_sel;
  wire [7:0] rd_tbl [0:15];
  wire [7:0] rd_byte;
  wire [15:0] data_all, dir_all, slew_all, pe_all, pol_all;
  wire [15:0] pin_view, data_view;
  wire [15:0] drive_next, oe_next, pull_act;
  wire [3:0] periph_own;

  // Bus phase tracking; hready gates the take so no request is seen during the read wait
  assign take = hsel & htrans[1] & hready;
  assign phase_next = take ? (hwrite ? MPC_PH_WR : MPC_PH_RD) : MPC_PH_IDLE;
  assign idx_next = take ? haddr[5:2] : idx_reg;
  assign hreadyout_next = ~(take & ~hwrite);
  assign wr_en = (phase_reg == MPC_PH_WR) & hready;
  assign rd_fill = (phase_reg == MPC_PH_RD);
  assign wr_sel = wr_en ? (16'h0001 << idx_reg) : 16'h0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= MPC_PH_IDLE;
      idx_reg <= 4'h0;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h00000000;
      hresp_reg <= `MPC_HRESP_OKAY;
    end else begin
      phase_reg <= phase_next;
      idx_reg <= idx_next;
      hreadyout_reg <= hreadyout_next;
      hrdata_reg <= hrdata_next;
      hresp_reg <= `MPC_HRESP_OKAY;
    end
  end

  // Register writes; input and unmapped indexes raise a select line that no register uses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_u_pin_data_reg <= `MPC_RST_DATA;
      port_u_direction_reg <= `MPC_RST_DIR;
      port_u_slew_control_reg <= `MPC_RST_SLEW;
      port_u_pull_enable_reg <= `MPC_RST_PE;
      port_u_pull_polarity_reg <= `MPC_RST_POL;
      port_v_pin_data_reg <= `MPC_RST_DATA;
      port_v_direction_reg <= `MPC_RST_DIR;
      port_v_slew_control_reg <= `MPC_RST_SLEW;
      port_v_pull_enable_reg <= `MPC_RST_PE;
      port_v_pull_polarity_reg <= `MPC_RST_POL;
    end else begin
      if (wr_sel[`MPC_IDX_U_DATA]) port_u_pin_data_reg <= hwdata[7:0];
      if (wr_sel[`MPC_IDX_U_DIR]) port_u_direction_reg <= hwdata[7:0];
      if (wr_sel[`MPC_IDX_U_SLEW]) port_u_slew_control_reg <= hwdata[7:0];
      if (wr_sel[`MPC_IDX_U_PE]) port_u_pull_enable_reg <= hwdata[7:0];
      if (wr_sel[`MPC_IDX_U_POL]) port_u_pull_polarity_reg <= hwdata[7:0];
      if (wr_sel[`MPC_IDX_V_DATA]) port_v_pin_data_reg <= hwdata[7:0];
      if (wr_sel[`MPC_IDX_V_DIR]) port_v_direction_reg <= hwdata[7:0];
      if (wr_sel[`MPC_IDX_V_SLEW]) port_v_slew_control_reg <= hwdata[7:0];
      if (wr_sel[`MPC_IDX_V_PE]) port_v_pull_enable_reg <= hwdata[7:0];
      if (wr_sel[`MPC_IDX_V_POL]) port_v_pull_polarity_reg <= hwdata[7:0];
    end
  end

  // Pin synchroniser; only the second stage is looked at
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync1_reg <= 16'h0000;
      pin_sync2_reg <= 16'h0000;
    end else begin
      pin_sync1_reg <= pin_in;
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  assign data_all = {port_v_pin_data_reg, port_u_pin_data_reg};
  assign dir_all = {port_v_direction_reg, port_u_direction_reg};
  assign slew_all = {port_v_slew_control_reg, port_u_slew_control_reg};
  assign pe_all = {port_v_pull_enable_reg, port_u_pull_enable_reg};
  assign pol_all = {port_v_pull_polarity_reg, port_u_pull_polarity_reg};

  // Disabled input buffer reads as 1; the view lags the pin by the synchroniser
  assign pin_view = slew_all | pin_sync2_reg;
  assign data_view = (dir_all & data_all) | (~dir_all & pin_view);

  // Read table, captured one cycle after the address phase so a preceding write is seen
  assign rd_tbl[`MPC_IDX_U_DATA] = data_view[7:0];
  assign rd_tbl[`MPC_IDX_U_IN] = pin_view[7:0];
  assign rd_tbl[`MPC_IDX_U_DIR] = port_u_direction_reg;
  assign rd_tbl[`MPC_IDX_U_SLEW] = port_u_slew_control_reg;
  assign rd_tbl[`MPC_IDX_U_PE] = port_u_pull_enable_reg;
  assign rd_tbl[`MPC_IDX_U_POL] = port_u_pull_polarity_reg;
  assign rd_tbl[`MPC_IDX_V_DATA] = data_view[15:8];
  assign rd_tbl[`MPC_IDX_V_IN] = pin_view[15:8];
  assign rd_tbl[`MPC_IDX_V_DIR] = port_v_direction_reg;
  assign rd_tbl[`MPC_IDX_V_SLEW] = port_v_slew_control_reg;
  assign rd_tbl[`MPC_IDX_V_PE] = port_v_pull_enable_reg;
  assign rd_tbl[`MPC_IDX_V_POL] = port_v_pull_polarity_reg;
  assign rd_tbl[12] = 8'h00;
  assign rd_tbl[13] = 8'h00;
  assign rd_tbl[14] = 8'h00;
  assign rd_tbl[15] = 8'h00;
  assign rd_byte = rd_tbl[idx_reg];
  assign hrdata_next = rd_fill ? {24'h000000, rd_byte} : hrdata_reg;

  // Ownership per group of four pins
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_grp
      assign periph_own[g] = stall_en[g] | pwm_en[g];
      assign drive_next[g*4+:4] = stall_en[g] ? stall_out[g*4+:4] :
                                  pwm_en[g] ? pwm_out[g*4+:4] : data_all[g*4+:4];
      assign oe_next[g*4+:4] = periph_own[g] ? 4'hF : dir_all[g*4+:4];
    end
  endgenerate

  // Pull only on inputs; an output owned by a peripheral never pulls
  assign pull_act = ~oe_next & pe_all;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_reg <= 16'h0000;
      pin_oe_reg <= 16'h0000;
      pin_pull_up_reg <= 16'h0000;
      pin_pull_down_reg <= 16'h0000;
      pin_slew_reg <= 16'h0000;
      pin_ibuf_en_reg <= `MPC_RST_IBUF;
    end else begin
      pin_out_reg <= drive_next;
      pin_oe_reg <= oe_next;
      pin_pull_up_reg <= pull_act & ~pol_all;
      pin_pull_down_reg <= pull_act & pol_all;
      pin_slew_reg <= slew_all;
      pin_ibuf_en_reg <= ~slew_all;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign pin_pull_up = pin_pull_up_reg;
  assign pin_pull_down = pin_pull_down_reg;
  assign pin_slew = pin_slew_reg;
  assign pin_ibuf_en = pin_ibuf_en_reg;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_take;
    take && !hwrite;
  endsequence

  sequence s_rd_answer;
    !hreadyout_reg ##1 hreadyout_reg;
  endsequence

  property p_rd_wait;
    s_rd_take |=> s_rd_answer;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read answer not after one wait state");

  property p_rd_data_u;
    (take && !hwrite && haddr[5:2] == `MPC_IDX_U_DATA) ##1 1'b1
      |=> (hrdata_reg[7:0] & $past(port_u_direction_reg)) ==
        ($past(port_u_pin_data_reg) & $past(port_u_direction_reg));
  endproperty
  a_rd_data_u: assert property (p_rd_data_u) else $error("output data read not from register");

  property p_rd_data_in;
    (take && !hwrite && haddr[5:2] == `MPC_IDX_V_DATA) ##1 (port_v_direction_reg == 8'h00)
      |=> hrdata_reg[7:0] == ($past(port_v_slew_control_reg) | $past(pin_sync2_reg[15:8]));
  endproperty
  a_rd_data_in: assert property (p_rd_data_in) else $error("input data read wrong");

  property p_rd_input;
    (take && !hwrite && haddr[5:2] == `MPC_IDX_U_IN) |=>
      ##1 hrdata_reg[7:0] == ($past(port_u_slew_control_reg) | $past(pin_sync2_reg[7:0]));
  endproperty
  a_rd_input: assert property (p_rd_input) else $error("input register read wrong");

  property p_wr_input;
    (phase_reg == MPC_PH_WR && hready && (idx_reg == `MPC_IDX_U_IN || idx_reg == `MPC_IDX_V_IN))
      |=> $stable(data_all) && $stable(dir_all) && $stable(slew_all) && $stable(pe_all) && $stable(pol_all);
  endproperty
  a_wr_input: assert property (p_wr_input) else $error("write to input register changed state");

  property p_wr_dir;
    (take && hwrite && haddr[5:2] == `MPC_IDX_U_DIR) ##1 hready
      |=> port_u_direction_reg == $past(hwdata[7:0]);
  endproperty
  a_wr_dir: assert property (p_wr_dir) else $error("direction write lost");

  property p_reset_pins;
    $rose(hresetn) |-> pin_oe == 16'h0000 && pin_pull_up == 16'h0000 && pin_pull_down == 16'h0000;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pin active right after reset");

  property p_no_pull_out;
    (pin_oe & (pin_pull_up | pin_pull_down)) == 16'h0000 && (pin_pull_up & pin_pull_down) == 16'h0000;
  endproperty
  a_no_pull_out: assert property (p_no_pull_out) else $error("pull device on an output");

  property p_pull_sel;
    (dir_all[0] == 1'b0 && !periph_own[0] && pe_all[0]) |=> pin_pull_up[0] == !$past(pol_all[0])
      && pin_pull_down[0] == $past(pol_all[0]);
  endproperty
  a_pull_sel: assert property (p_pull_sel) else $error("pull polarity wrong");

  property p_slew;
    ##1 pin_ibuf_en == ~pin_slew && pin_slew == $past(slew_all);
  endproperty
  a_slew: assert property (p_slew) else $error("slew and input buffer mismatch");

  sequence s_wr_take;
    take && hwrite;
  endsequence

  property p_wr_nowait;
    s_wr_take |=> hreadyout_reg && hresp_reg == `MPC_HRESP_OKAY;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write data phase stalled");

  property p_rd_upper;
    s_rd_take |=> ##1 hrdata_reg[31:8] == 24'h000000 && hresp_reg == `MPC_HRESP_OKAY;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits not zero");

  property p_rd_unmapped;
    (take && !hwrite && haddr[5:4] == 2'h3) |=> ##1 hrdata_reg == 32'h00000000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  // Output bits of port V must read the stored bit even when a peripheral drives the pin
  property p_rd_data_v;
    (take && !hwrite && haddr[5:2] == `MPC_IDX_V_DATA) ##1 1'b1
      |=> (hrdata_reg[7:0] & $past(port_v_direction_reg)) ==
        ($past(port_v_pin_data_reg) & $past(port_v_direction_reg));
  endproperty
  a_rd_data_v: assert property (p_rd_data_v) else $error("port V output data read not from register");

  property p_wr_slew;
    (s_wr_take ##0 haddr[5:2] == `MPC_IDX_U_SLEW) ##1 hready
      |=> port_u_slew_control_reg == $past(hwdata[7:0]);
  endproperty
  a_wr_slew: assert property (p_wr_slew) else $error("slew write lost");

  property p_reset_drive;
    $rose(hresetn) |-> pin_out == 16'h0000 && pin_slew == 16'h0000 && pin_ibuf_en == `MPC_RST_IBUF;
  endproperty
  a_reset_drive: assert property (p_reset_drive) else $error("pin drive active right after reset");

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chk
      property p_stall_own;
        stall_en[g] |=> pin_oe[g*4+:4] == 4'hF && pin_out[g*4+:4] == $past(stall_out[g*4+:4]);
      endproperty
      a_stall_own: assert property (p_stall_own) else $error("stall detector not driving");

      property p_pwm_own;
        (!stall_en[g] && pwm_en[g]) |=> pin_oe[g*4+:4] == 4'hF && pin_out[g*4+:4] == $past(pwm_out[g*4+:4]);
      endproperty
      a_pwm_own: assert property (p_pwm_own) else $error("motor PWM not driving");

      property p_gpio_own;
        (!stall_en[g] && !pwm_en[g]) |=> pin_oe[g*4+:4] == $past(dir_all[g*4+:4])
          && (pin_out[g*4+:4] == $past(data_all[g*4+:4]));
      endproperty
      a_gpio_own: assert property (p_gpio_own) else $error("direction bits not in control");
    end
  endgenerate

endmodule : mpc_port_ctrl

// ==== testbench/mpc_far_model.sv ====
// Purpose: Pads and pull resistors beyond the motor port pin control
// Assumes: Pads settle well within one clock
// Notes: An undriven, unpulled pad shows the outside level
module mpc_far_model (
  // Pad drive from the block
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pin_pull_up,
  input wire logic [15:0] pin_pull_down,
  // Level imposed from outside
  input wire logic [15:0] ext_level,
  // Pad level seen by the block
  output logic [15:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Drive beats pull, pull beats the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_pull_up) |
                  (~pin_oe & ~pin_pull_up & ~pin_pull_down & ext_level);
endmodule : mpc_far_model

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench of the motor port pin control
// Assumes: Reads take one wait state, writes none
// Notes: Peripheral drive values are fixed patterns
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp;
  logic [31:0] hrdata, rd;
  logic [3:0] stall_en = 4'h0;
  logic [3:0] pwm_en = 4'h0;
  logic [15:0] stall_out = 16'hA5C3;
  logic [15:0] pwm_out = 16'h5A3C;
  logic [15:0] ext = 16'h9966;
  logic [15:0] dir = 16'h3CF0;
  logic [15:0] dat = 16'h00A5;
  logic [15:0] pin_in, pin_out, pin_oe, pull_up, pull_dn, slew, ibuf;
  int fail_count = 0;
  int tests_run = 0;
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  mpc_port_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .stall_en(stall_en), .stall_out(stall_out), .pwm_en(pwm_en),
    .pwm_out(pwm_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pull_up),
    .pin_pull_down(pull_dn), .pin_slew(slew), .pin_ibuf_en(ibuf));
  mpc_far_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pull_up),
    .pin_pull_down(pull_dn), .ext_level(ext), .pin_in(pin_in));
  task close_out();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  // Bounded wait, a stuck slave ends the run
  task wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      fail_count++;
      close_out();
    end
  endtask : wait_rdy
  task xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {26'h0, idx, 2'h0};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : xfer
  // Covers pin update plus two synchroniser stages
  task settle();
    repeat (4) @(posedge hclk);
  endtask : settle
  task t_reset();
    repeat (2) @(posedge hclk);
    chk(pin_oe, 16'h0000);
    chk(pull_up | pull_dn, 16'h0000);
    chk(ibuf, 16'hFFFF);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 2; i < 16; i++) begin
      if (i != 6 && i != 7) begin
        xfer(1'b0, i[3:0], 8'h00);
        chk(rd, 32'h0);
      end
    end
    xfer(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h66);
    xfer(1'b0, 4'h6, 8'h00);
    chk(rd, 32'h99);
    xfer(1'b0, 4'h7, 8'h00);
    chk(rd, 32'h99);
    $display("reset test done");
  endtask : t_reset
  task t_gpio();
    xfer(1'b1, 4'h2, 8'hF0);
    xfer(1'b1, 4'h0, 8'hA5);
    settle();
    chk(pin_oe[7:0], 8'hF0);
    chk(pin_out[7:4], 4'hA);
    xfer(1'b0, 4'h0, 8'h00);
    chk(rd, 32'hA6);
    xfer(1'b0, 4'h1, 8'h00);
    chk(rd, 32'hA6);
    $display("gpio test done");
  endtask : t_gpio
  task t_slew();
    xfer(1'b1, 4'h3, 8'h0F);
    settle();
    chk(slew[7:0], 8'h0F);
    chk(ibuf[7:0], 8'hF0);
    xfer(1'b0, 4'h0, 8'h00);
    chk(rd, 32'hAF);
    xfer(1'b1, 4'h1, 8'h00);
    xfer(1'b0, 4'h1, 8'h00);
    chk(rd, 32'hAF);
    xfer(1'b0, 4'h2, 8'h00);
    chk(rd, 32'hF0);
    xfer(1'b1, 4'h3, 8'h00);
    $display("slew test done");
  endtask : t_slew
  task t_pull();
    xfer(1'b1, 4'h4, 8'hFF);
    xfer(1'b1, 4'h5, 8'h81);
    settle();
    chk(pull_dn[7:0], 8'h01);
    chk(pull_up[7:0], 8'h0E);
    xfer(1'b0, 4'h1, 8'h00);
    chk(rd, 32'hAE);
    xfer(1'b0, 4'h5, 8'h00);
    chk(rd, 32'h81);
    xfer(1'b1, 4'h4, 8'h00);
    settle();
    chk(pull_up | pull_dn, 16'h0000);
    $display("pull test done");
  endtask : t_pull
  // Each group: stall over PWM, then PWM, then direction bits
  task t_owner();
    xfer(1'b1, 4'h8, 8'h3C);
    for (int g = 0; g < 4; g++) begin
      stall_en <= 4'h1 << g;
      pwm_en <= 4'hF;
      settle();
      chk(pin_oe[4*g +: 4], 4'hF);
      chk(pin_out[4*g +: 4], stall_out[4*g +: 4]);
      // Owned pins differ from the stored bits in two of each four, so this tells stored data from pin level there
      xfer(1'b0, (g < 2) ? 4'h0 : 4'h6, 8'h00);
      chk(rd[4*(g%2) +: 4], (dir[4*g +: 4] & dat[4*g +: 4]) | (~dir[4*g +: 4] & stall_out[4*g +: 4]));
      stall_en <= 4'h0;
      settle();
      chk(pin_oe[4*g +: 4], 4'hF);
      chk(pin_out[4*g +: 4], pwm_out[4*g +: 4]);
      pwm_en <= 4'h0;
      settle();
      chk(pin_oe[4*g +: 4], dir[4*g +: 4]);
    end
    $display("owner test done");
  endtask : t_owner
  initial begin
    t_reset();
    t_gpio();
    t_slew();
    t_pull();
    t_owner();
    close_out();
  end
endmodule : tb_top
